// >>> rtl/rps_defs.svh
`ifndef RPS_DEFS_SVH
`define RPS_DEFS_SVH

// APB word offsets (byte addresses)
`define RPS_OFF_PTR_HI   12'h000
`define RPS_OFF_PTR_LO   12'h004
`define RPS_OFF_SELECT   12'h008
`define RPS_OFF_CONFIG   12'h00c

// Pointer high field positions
`define RPS_BIT_DIR      7
`define RPS_BIT_STEP     6
`define RPS_UPPER_MSB    2
`define RPS_UPPER_LSB    0

// Selector and configuration fields
`define RPS_SEL_MSB      2
`define RPS_CFG_SHR_MSB  1
`define RPS_CFG_OWN_LSB  2

// Reset values
`define RPS_RST_PTR      11'h000
`define RPS_RST_BYTE     8'h00
`define RPS_RST_SEL      3'h0
`define RPS_RST_CFG_OWN  6'h00

// Highest selector code with a defined target
`define RPS_SEL_LAST     3'h4

`endif

// >>> rtl/rps_pkg.sv
package rps_pkg;

    // Targets reachable through host address 07
    typedef enum logic [2:0] {
        RPS_TGT_TENTATIVE_ID = 3'h0,
        RPS_TGT_NODE_ID      = 3'h1,
        RPS_TGT_SETUP_ONE    = 3'h2,
        RPS_TGT_NEXT_ID      = 3'h3,
        RPS_TGT_SETUP_TWO    = 3'h4,
        RPS_TGT_RSVD5        = 3'h5,
        RPS_TGT_RSVD6        = 3'h6,
        RPS_TGT_RSVD7        = 3'h7
    } rps_target_type;

    typedef logic [10:0] rps_ptr_type;

endpackage

// >>> rtl/rps_pointer.sv
`timescale 1ns/1ps
`include "rps_defs.svh"
module rps_pointer
    import rps_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic reset_i,
    rps_ptr_if.ptr_side pif
);

    rps_ptr_type ptr_q;
    rps_ptr_type ptr_d;
    logic        dir_q;
    logic        dir_d;
    logic        step_q;
    logic        step_d;

    // Next pointer state; a host write beats a same-cycle data access
    always_comb begin
        ptr_d  = ptr_q;
        dir_d  = dir_q;
        step_d = step_q;
        if (pif.wr_hi) begin
            dir_d  = pif.wdata[`RPS_BIT_DIR];
            step_d = pif.wdata[`RPS_BIT_STEP];
            ptr_d[10:8] = pif.wdata[`RPS_UPPER_MSB:`RPS_UPPER_LSB];
        end else if (pif.wr_lo) begin
            ptr_d[7:0] = pif.wdata;
        end else if (pif.access && step_q) begin
            ptr_d = ptr_q + 11'h001;  // Wraps at top of 2K
        end
    end

    // Pointer registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ptr_q  <= `RPS_RST_PTR;
            dir_q  <= 1'b0;
            step_q <= 1'b0;
        end else begin
            ptr_q  <= ptr_d;
            dir_q  <= dir_d;
            step_q <= step_d;
        end
    end

    assign pif.ptr     = ptr_q;
    assign pif.dir     = dir_q;
    assign pif.step_en = step_q;

endmodule

// >>> rtl/rps_ptr_if.sv
`timescale 1ns/1ps
interface rps_ptr_if;
    logic        wr_hi;
    logic        wr_lo;
    logic [7:0]  wdata;
    logic        access;
    logic [10:0] ptr;
    logic        dir;
    logic        step_en;

    modport ptr_side (
        input  wr_hi,
        input  wr_lo,
        input  wdata,
        input  access,
        output ptr,
        output dir,
        output step_en
    );

    modport ctl_side (
        output wr_hi,
        output wr_lo,
        output wdata,
        output access,
        input  ptr,
        input  dir,
        input  step_en
    );
endinterface

// >>> rtl/rps_top.sv
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "rps_defs.svh"
module rps_top
    import rps_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              CLK_I,
    input  wire logic              RESET_I,
    input  wire logic              PSEL_I,
    input  wire logic              PENABLE_I,
    input  wire logic              PWRITE_I,
    input  wire logic [ADDR_W-1:0] PADDR_I,
    input  wire logic [31:0]       PWDATA_I,
    output logic      [31:0]       PRDATA_O,
    output logic                   PREADY_O,
    output logic                   PSLVERR_O,
    input  wire logic              DATA_ACCESS_I,
    output logic      [10:0]       RAM_ADDR_O,
    output logic                   RAM_READ_O,
    output logic      [2:0]        SELECT_O,
    output logic                   SELECT_RSVD_O
);

    rps_ptr_if pif ();

    logic        setup;
    logic        wr_en;
    logic        hit_hi;
    logic        hit_lo;
    logic        hit_sel;
    logic        hit_cfg;
    logic        mapped;
    logic [2:0]  sel_q;
    logic [2:0]  sel_d;
    logic [5:0]  cfg_own_q;
    logic [5:0]  cfg_own_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        err_q;
    logic        err_d;

    // Selector code without a defined target
    function automatic logic is_reserved(input logic [2:0] code);
        return code > `RPS_SEL_LAST;
    endfunction

    // Offset match, compared on the full address
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [11:0]       off);
        return a == ADDR_W'(off);
    endfunction

    // APB decode; zero wait states, so the access phase always completes
    assign setup   = PSEL_I && !PENABLE_I;
    assign wr_en   = PSEL_I && PENABLE_I && PWRITE_I;
    assign hit_hi  = hit(PADDR_I, `RPS_OFF_PTR_HI);
    assign hit_lo  = hit(PADDR_I, `RPS_OFF_PTR_LO);
    assign hit_sel = hit(PADDR_I, `RPS_OFF_SELECT);
    assign hit_cfg = hit(PADDR_I, `RPS_OFF_CONFIG);
    assign mapped  = hit_hi || hit_lo || hit_sel || hit_cfg;
    assign PREADY_O = 1'b1;

    // Pointer control towards the counter
    assign pif.wr_hi  = wr_en && hit_hi;
    assign pif.wr_lo  = wr_en && hit_lo;
    assign pif.wdata  = PWDATA_I[7:0];
    assign pif.access = DATA_ACCESS_I;

    rps_pointer u_pointer (
        .clk_i   (CLK_I),
        .reset_i (RESET_I),
        .pif     (pif)
    );

    // Selector and configuration next state
    always_comb begin
        sel_d     = sel_q;
        cfg_own_d = cfg_own_q;
        if (wr_en && hit_sel) begin
            sel_d = PWDATA_I[`RPS_SEL_MSB:0];
        end else if (wr_en && hit_cfg) begin
            sel_d[`RPS_CFG_SHR_MSB:0] = PWDATA_I[`RPS_CFG_SHR_MSB:0];
            sel_d[`RPS_SEL_MSB] = 1'b0;
            cfg_own_d = PWDATA_I[7:`RPS_CFG_OWN_LSB];
        end
    end

    // Selector and configuration registers
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            sel_q     <= `RPS_RST_SEL;
            cfg_own_q <= `RPS_RST_CFG_OWN;
        end else begin
            sel_q     <= sel_d;
            cfg_own_q <= cfg_own_d;
        end
    end

    // Read data captured in setup so it stands through the access phase
    always_comb begin
        rdata_d = rdata_q;
        err_d   = 1'b0;
        if (setup) begin
            rdata_d = 32'h0000_0000;
            err_d   = !mapped;
            if (hit_hi) begin
                rdata_d[7:0] = {pif.dir, pif.step_en, 3'h0, pif.ptr[10:8]};
            end else if (hit_lo) begin
                rdata_d[7:0] = pif.ptr[7:0];
            end else if (hit_sel) begin
                rdata_d[2:0] = sel_q;
            end else if (hit_cfg) begin
                rdata_d[7:0] = {cfg_own_q, sel_q[`RPS_CFG_SHR_MSB:0]};
            end
        end
    end

    // Read data and error registers
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end

    // Registered outputs; the error flag is shown only in the access phase
    assign PRDATA_O      = rdata_q;
    assign PSLVERR_O     = err_q && PSEL_I && PENABLE_I;
    assign RAM_ADDR_O    = pif.ptr;
    assign RAM_READ_O    = pif.dir;
    assign SELECT_O      = sel_q;
    assign SELECT_RSVD_O = is_reserved(sel_q);

    // Checks on the register behaviour
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);

    a_dir_from_write: assert property (
        pif.wr_hi |=> RAM_READ_O == $past(PWDATA_I[7]))
        else $error("direction bit not taken from pointer high write");

    a_step_advances: assert property (
        DATA_ACCESS_I && pif.step_en && !pif.wr_hi && !pif.wr_lo
        |=> RAM_ADDR_O == 11'($past(RAM_ADDR_O) + 11'h001))
        else $error("pointer did not advance after access");

    a_step_holds: assert property (
        !pif.step_en && !pif.wr_hi && !pif.wr_lo |=> $stable(RAM_ADDR_O))
        else $error("pointer moved with stepping off");

    a_upper_from_hi: assert property (
        pif.wr_hi |=> RAM_ADDR_O[10:8] == $past(PWDATA_I[2:0])
                      && RAM_ADDR_O[7:0] == $past(RAM_ADDR_O[7:0]))
        else $error("upper pointer bits wrong after write");

    a_lower_from_lo: assert property (
        pif.wr_lo |=> RAM_ADDR_O[7:0] == $past(PWDATA_I[7:0])
                      && RAM_ADDR_O[10:8] == $past(RAM_ADDR_O[10:8]))
        else $error("lower pointer bits wrong after write");

    a_reserved_zero: assert property (
        setup && hit_hi |=> PRDATA_O[5:3] == 3'h0
                            && PRDATA_O[2:0] == $past(RAM_ADDR_O[10:8]))
        else $error("pointer high read shows wrong bits");

    a_select_write: assert property (
        wr_en && hit_sel |=> SELECT_O == $past(PWDATA_I[2:0])
            && SELECT_RSVD_O == ($past(PWDATA_I[2:0]) > 3'h4))
        else $error("selector not loaded from write");

    a_shared_bits: assert property (
        setup && hit_cfg |=> PRDATA_O[1:0] == SELECT_O[1:0])
        else $error("configuration read misses shared selector bits");

    a_msb_cleared: assert property (
        wr_en && hit_cfg |=> SELECT_O == {1'b0, $past(PWDATA_I[1:0])})
        else $error("configuration write left selector top bit");

    a_carry_up: assert property (
        DATA_ACCESS_I && pif.step_en && !pif.wr_hi && !pif.wr_lo
        && RAM_ADDR_O[7:0] == 8'hff
        |=> RAM_ADDR_O[7:0] == 8'h00
            && RAM_ADDR_O[10:8] == 3'($past(RAM_ADDR_O[10:8]) + 3'h1))
        else $error("low byte did not carry into upper bits");

    // Direction only moves on a pointer high write
    a_dir_holds: assert property (
        !pif.wr_hi |=> $stable(RAM_READ_O))
        else $error("direction changed without pointer high write");

    // Direction and step flags read back on pointer high
    a_hi_read_flags: assert property (
        setup && hit_hi |=> PRDATA_O[7] == $past(RAM_READ_O)
                            && PRDATA_O[6] == $past(pif.step_en))
        else $error("pointer high read shows wrong flags");

    // Step enable only moves on a pointer high write
    a_step_en_holds: assert property (
        !pif.wr_hi |=> $stable(pif.step_en))
        else $error("step enable changed without pointer high write");

    // A pointer write beats a same-cycle data access
    a_write_wins: assert property (
        DATA_ACCESS_I && pif.step_en && pif.wr_lo
        |=> RAM_ADDR_O == {$past(RAM_ADDR_O[10:8]), $past(PWDATA_I[7:0])})
        else $error("data access stepped over a pointer low write");

    // Low pointer byte read back as it stood in setup
    a_lower_read: assert property (
        setup && hit_lo |=> PRDATA_O[7:0] == $past(RAM_ADDR_O[7:0]))
        else $error("pointer low read shows wrong byte");

    // Selector only moves on selector or configuration writes
    a_select_holds: assert property (
        !(wr_en && (hit_sel || hit_cfg)) |=> $stable(SELECT_O))
        else $error("selector changed without a write");

endmodule

// >>> tb/rps_host.sv
`timescale 1ns/1ps
module rps_host (
    input  wire logic        clk_i,
    input  wire logic [31:0] prdata_i,
    input  wire logic        pready_i,
    input  wire logic        pslverr_i,
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic      [11:0] paddr_o,
    output logic      [31:0] pwdata_o
);
    // Idle bus at time zero
    initial begin
        psel_o    = 1'b0;
        penable_o = 1'b0;
        pwrite_o  = 1'b0;
        paddr_o   = 12'h000;
        pwdata_o  = 32'h0;
    end

    // One transfer; released lines flip so stale data never looks valid
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [7:0] d, output logic [31:0] rd,
                        output logic e);
        @(posedge clk_i);
        psel_o    <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o  <= w;
        paddr_o   <= a;
        pwdata_o  <= {24'h0, d};
        @(posedge clk_i);
        penable_o <= 1'b1;
        // No wait count assumed; the bench watchdog ends a hang
        do @(posedge clk_i); while (pready_i !== 1'b1);
        rd = prdata_i;
        e  = pslverr_i;
        psel_o    <= 1'b0;
        penable_o <= 1'b0;
        paddr_o   <= ~a;
        pwdata_o  <= ~{24'h0, d};
    endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`include "rps_defs.svh"
module tb_top;
    import rps_pkg::*;
    typedef struct packed {
        logic [11:0] wa;
        logic [7:0]  wd;
        logic [11:0] ra;
        logic [7:0]  re;
    } rps_row_type;
    logic        clk, rst, acc, psel, pen, pwr, prdy, perr, ram_rd, rsvd, err;
    logic [11:0] pa;
    logic [31:0] pwd, prd, rdv;
    logic [10:0] ram_addr;
    logic [2:0]  sel;
    int          fail_count = 0;
    int          compares = 0;
    // Write then read back; reserved pointer bits read as zero
    rps_row_type rows [6] = '{
        '{`RPS_OFF_PTR_HI, 8'hff, `RPS_OFF_PTR_HI, 8'hc7},
        '{`RPS_OFF_PTR_LO, 8'ha5, `RPS_OFF_PTR_LO, 8'ha5},
        '{`RPS_OFF_SELECT, 8'h07, `RPS_OFF_SELECT, 8'h07},
        '{`RPS_OFF_CONFIG, 8'hfc, `RPS_OFF_SELECT, 8'h00},
        '{`RPS_OFF_SELECT, 8'h05, `RPS_OFF_CONFIG, 8'hfd},
        '{`RPS_OFF_CONFIG, 8'h02, `RPS_OFF_SELECT, 8'h02}};

    rps_top uut (.CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd),
        .PREADY_O(prdy), .PSLVERR_O(perr), .DATA_ACCESS_I(acc),
        .RAM_ADDR_O(ram_addr), .RAM_READ_O(ram_rd), .SELECT_O(sel),
        .SELECT_RSVD_O(rsvd));
    rps_host host (.clk_i(clk), .prdata_i(prd), .pready_i(prdy),
        .pslverr_i(perr), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr),
        .paddr_o(pa), .pwdata_o(pwd));

    // Free running clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, d, rdv, err);
        #1;
    endtask
    task automatic rdc(input string n, input logic [11:0] a,
                       input logic [7:0] e);
        host.xfer(1'b0, a, 8'h00, rdv, err);
        chk(n, {24'h0, e}, rdv);
    endtask
    // One data access pulse, pointer sampled once it lands
    task automatic pulse(input logic [10:0] e);
        @(posedge clk);
        acc <= 1'b1;
        @(posedge clk);
        acc <= 1'b0;
        #1;
        chk("ram_addr", {21'h0, e}, {21'h0, ram_addr});
    endtask
    task automatic report_and_stop;
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog, far beyond the roughly 130 cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        acc = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rdc("ptr_hi", `RPS_OFF_PTR_HI, 8'h00);
        rdc("select", `RPS_OFF_SELECT, 8'h00);
        chk("ram_addr", 32'h0, {21'h0, ram_addr});
        for (int i = 0; i < 6; i++) begin
            wr(rows[i].wa, rows[i].wd);
            rdc("row", rows[i].ra, rows[i].re);
        end
        wr(`RPS_OFF_PTR_HI, 8'h40);
        wr(`RPS_OFF_PTR_LO, 8'hff);
        chk("ram_read", 32'h0, {31'h0, ram_rd});
        pulse(11'h100);
        pulse(11'h101);
        wr(`RPS_OFF_PTR_HI, 8'h47);
        wr(`RPS_OFF_PTR_LO, 8'hff);
        chk("ram_addr", 32'h7ff, {21'h0, ram_addr});
        pulse(11'h000);
        wr(`RPS_OFF_PTR_HI, 8'h82);
        pulse(11'h200);
        chk("ram_read", 32'h1, {31'h0, ram_rd});
        for (int c = 0; c < 8; c++) begin
            wr(`RPS_OFF_SELECT, c[7:0]);
            chk("select_o", c, {29'h0, sel});
            chk("select_rsvd", (c > 4), {31'h0, rsvd});
        end
        wr(`RPS_OFF_CONFIG, 8'h01);
        chk("select_o", 32'h1, {29'h0, sel});
        // Pointer low write and data access on one edge: write wins
        wr(`RPS_OFF_PTR_HI, 8'h40);
        fork
            wr(`RPS_OFF_PTR_LO, 8'h10);
            begin
                repeat (2) @(posedge clk);
                acc <= 1'b1;
                @(posedge clk);
                acc <= 1'b0;
            end
        join
        chk("ram_addr", 32'h010, {21'h0, ram_addr});
        // Mid-run reset brings every register back
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc("rst_ptr_hi", `RPS_OFF_PTR_HI, 8'h00);
        chk("rst_ram_addr", 32'h0, {21'h0, ram_addr});
        chk("rst_select", 32'h0, {29'h0, sel});
        // Unmapped place refuses both directions
        host.xfer(1'b1, 12'h010, 8'h5a, rdv, err);
        chk("slverr_wr", 32'h1, {31'h0, err});
        host.xfer(1'b0, 12'h010, 8'h00, rdv, err);
        chk("slverr_rd", 32'h1, {31'h0, err});
        chk("rdata_unmapped", 32'h0, rdv);
        chk("pready", 32'h1, {31'h0, prdy});
        report_and_stop();
    end
endmodule
